//--- icc_ctl_properties.sv
// Purpose: Port-level checks of the interrupt controller
// Assumes: Host write and first acknowledge strobes stay low six cycles; strobes stay high five or more
// Notes:   Bound to the top module at the foot of this file

`timescale 1ns/10ps

module icc_ctl_properties (
   input wire logic       CORE_CLK,
   input wire logic       RSTN,
   input wire logic       CS_N,
   input wire logic       RD_N,
   input wire logic       WR_N,
   input wire logic [2:0] ADDR,
   input wire logic [7:0] DIN,
   input wire logic       ACK_STROBE_N,
   input wire logic [7:0] REQUEST_LINE,
   input wire logic [7:0] READ_BUS,
   input wire logic       READ_BUS_EN,
   input wire logic       IRQ_OUT
);
   logic       wr_q;
   logic       ack_odd_q;
   logic [2:0] wa_q;
   logic [7:0] wd_q;
   logic [7:0] mask_q;
   logic [7:0] base_q;

   // ****************************************
   // Shadow of host writes and ack parity
   // ****************************************
   // Commit on the strobe's end, as the block does, so mask checks do not run early
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         wr_q      <= 1'b0;
         ack_odd_q <= 1'b0;
         wa_q      <= 3'h0;
         wd_q      <= 8'h00;
         mask_q    <= icc_pkg::MASK_RST;
         base_q    <= icc_pkg::IW_RST;
      end else begin
         wr_q <= !CS_N && !WR_N;
         if (!CS_N && !WR_N) begin
            wa_q <= ADDR;
            wd_q <= DIN;
         end
         if (wr_q && WR_N && wa_q == icc_pkg::ADDR_MASK) begin
            mask_q <= wd_q;
         end
         if (wr_q && WR_N && wa_q == icc_pkg::ADDR_IW2) begin
            base_q <= wd_q;
         end
         if ($fell(ACK_STROBE_N)) begin
            ack_odd_q <= !ack_odd_q;
         end
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);

   // Bus left alone long enough for any drive to end
   sequence quiet_s;
      ((RD_N || CS_N) && ACK_STROBE_N)[*6];
   endsequence
   // First pulse of an acknowledge pair begins
   sequence first_fall_s;
      $fell(ACK_STROBE_N) && !ack_odd_q;
   endsequence

   reset_quiet_a:
      assert property ($rose(RSTN) |-> !IRQ_OUT && !READ_BUS_EN) else $error("active after reset");
   mask_all_a:
      assert property ((mask_q == 8'hFF)[*8] |-> !IRQ_OUT) else $error("irq while all masked");
   first_quiet_a:
      assert property (first_fall_s |-> !READ_BUS_EN[*6]) else $error("bus driven in first ack");
   vector_base_a:
      assert property (READ_BUS_EN && !ACK_STROBE_N && !ack_odd_q |-> READ_BUS[7:3] == base_q[7:3])
         else $error("vector base wrong");
   irq_ack_drop_a:
      assert property (first_fall_s ##0 IRQ_OUT |-> ##[1:6] !IRQ_OUT) else $error("irq kept in ack");
   read_answer_a:
      assert property ($fell(RD_N) && !CS_N |-> ##[2:6] READ_BUS_EN) else $error("read unanswered");
   drive_cause_a:
      assert property ($rose(READ_BUS_EN) |-> $past(!RD_N || !ACK_STROBE_N, 2))
         else $error("drive without strobe");
   bus_quiet_a:
      assert property (quiet_s |-> !READ_BUS_EN) else $error("bus driven when idle");
endmodule

bind icc_interrupt_controller icc_ctl_properties chk_u (
   .CORE_CLK(CORE_CLK), .RSTN(RSTN), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .ADDR(ADDR),
   .DIN(DIN), .ACK_STROBE_N(ACK_STROBE_N), .REQUEST_LINE(REQUEST_LINE),
   .READ_BUS(READ_BUS), .READ_BUS_EN(READ_BUS_EN), .IRQ_OUT(IRQ_OUT));

//--- icc_host_model.sv
// Purpose: Behavioural host issuing register and acknowledge cycles
// Assumes: Write and first acknowledge strobes held six cycles low, others until the enable; at least five high
// Notes:   Released address and data show the inverse of the last value

`timescale 1ns/10ps

module icc_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] read_bus,
   input  wire logic       read_bus_en,
   output logic            cs_n,
   output logic            rd_n,
   output logic            wr_n,
   output logic      [2:0] addr,
   output logic      [7:0] din,
   output logic            ack_n
);
   // ****************************************
   // Bus cycles
   // ****************************************
   // Idle levels at time zero
   initial begin
      cs_n  = 1'b1;
      rd_n  = 1'b1;
      wr_n  = 1'b1;
      ack_n = 1'b1;
      addr  = 3'h0;
      din   = 8'h00;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Hold the strobe until the enable is seen at an edge; bounded wait
   task automatic take(output logic [7:0] v);
      v = 8'hXX;
      for (int i = 0; i < 12; i++) begin
         @(posedge clk);
         if (read_bus_en === 1'b1) begin
            v = read_bus;
            break;
         end
      end
      #1;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      cs_n = 1'b0;
      wr_n = 1'b0;
      addr = a;
      din  = d;
      step(6);
      // Address and data held past the strobe's end, where the block samples them
      wr_n = 1'b1;
      step(3);
      cs_n = 1'b1;
      addr = ~a;
      din  = ~d;
      step(3);
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      cs_n = 1'b0;
      rd_n = 1'b0;
      addr = a;
      take(v);
      rd_n = 1'b1;
      cs_n = 1'b1;
      addr = ~a;
      step(5);
   endtask

   // Two pulses; the vector is taken during the second
   task automatic ack(output logic [7:0] v);
      ack_n = 1'b0;
      step(6);
      ack_n = 1'b1;
      step(6);
      ack_n = 1'b0;
      take(v);
      ack_n = 1'b1;
      step(6);
   endtask
endmodule

//--- icc_interrupt_controller.sv
// Purpose: Eight-level interrupt controller with single-byte acknowledge
// Assumes: All pins asynchronous to CORE_CLK; strobes held two cycles+
// Notes:   Register map and strobe handling described below

`timescale 1ns/10ps

module icc_interrupt_controller (
   input  wire logic       CORE_CLK,
   input  wire logic       RSTN,
   input  wire logic       CS_N,
   input  wire logic       RD_N,
   input  wire logic       WR_N,
   input  wire logic [2:0] ADDR,
   input  wire logic [7:0] DIN,
   input  wire logic       ACK_STROBE_N,
   input  wire logic [7:0] REQUEST_LINE,
   output logic      [7:0] READ_BUS,
   output logic            READ_BUS_EN,
   output logic            IRQ_OUT
);

   // ****************************************
   // State record
   // ****************************************
   typedef struct packed {
      logic [7:0]            req_s1;
      logic [7:0]            req_s2;
      logic [7:0]            req_p;
      logic [3:0]            ctl_s1;
      logic [3:0]            ctl_s2;
      logic [3:0]            ctl_p;
      logic [2:0]            addr_s1;
      logic [2:0]            addr_s2;
      logic [7:0]            din_s1;
      logic [7:0]            din_s2;
      logic [7:0]            pending_request_bits;
      logic [7:0]            in_service_bits;
      logic [7:0]            imr;
      logic [7:0]            iw1;
      logic [7:0]            iw2;
      logic [7:0]            iw4;
      logic [2:0]            lowest;
      logic                  rot_auto_end_of_service;
      logic                  selective_mask_mode;
      logic                  read_isr;
      logic                  poll_arm;
      icc_pkg::icc_state_type st;
      logic [2:0]            svc_lvl;
      logic                  svc_ok;
      logic [7:0]            dout;
      logic                  dout_en;
      logic                  irq;
   } icc_regs_type;

   icc_regs_type q;
   icc_regs_type d;

   icc_res_if pend_rq ();
   icc_res_if serv_rq ();

   logic [7:0] cand;
   logic       eligible;
   logic       level_mode;
   logic       wr_take;
   logic       rd_take;
   logic       ack_fall;
   logic       ack_rise;

   // ****************************************
   // Helpers
   // ****************************************
   // Rank of a level, 0 is the top
   function automatic logic [2:0] rank(input logic [2:0] lvl,
                                       input logic [2:0] low);
      rank = lvl - low - 3'h1;
   endfunction

   // One-hot of a level
   function automatic logic [7:0] onehot(input logic [2:0] lvl);
      onehot = 8'h01 << lvl;
   endfunction

   // ****************************************
   // Priority resolvers
   // ****************************************
   icc_resolver u_pend (
      .p (pend_rq.res)
   );

   icc_resolver u_serv (
      .p (serv_rq.res)
   );

   // Candidates and eligibility
   always_comb begin
      cand = q.pending_request_bits & ~q.imr;
      if (q.selective_mask_mode) begin
         cand = cand & ~q.in_service_bits;
      end
      pend_rq.req    = cand;
      pend_rq.lowest = q.lowest;
      serv_rq.req    = q.in_service_bits;
      serv_rq.lowest = q.lowest;
      // Outside selective mask, only a level above all served ones counts
      eligible = pend_rq.valid && (q.selective_mask_mode || !serv_rq.valid ||
                 rank(pend_rq.level, q.lowest) <
                 rank(serv_rq.level, q.lowest));
   end

   // Strobe edges; write taken at its end so data is settled
   always_comb begin
      level_mode = q.iw1[icc_pkg::IW1_LEVEL_BIT];
      wr_take  = !q.ctl_p[icc_pkg::CTL_WR] && q.ctl_s2[icc_pkg::CTL_WR] &&
                 !q.ctl_p[icc_pkg::CTL_CS];
      rd_take  = q.ctl_p[icc_pkg::CTL_RD] && !q.ctl_s2[icc_pkg::CTL_RD] &&
                 !q.ctl_s2[icc_pkg::CTL_CS];
      ack_fall = q.ctl_p[icc_pkg::CTL_ACK] && !q.ctl_s2[icc_pkg::CTL_ACK];
      ack_rise = !q.ctl_p[icc_pkg::CTL_ACK] && q.ctl_s2[icc_pkg::CTL_ACK];
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [7:0] irr_set;
      logic [7:0] irr_clr;
      logic [7:0] isr_set;
      logic [7:0] isr_clr;
      logic [2:0] cmd_lvl;
      irr_set = 8'h00;
      irr_clr = 8'h00;
      isr_set = 8'h00;
      isr_clr = 8'h00;
      cmd_lvl = q.din_s2[2:0];
      d = q;

      // Two-stage synchronisers, then one stage of history
      d.req_s1  = REQUEST_LINE;
      d.req_s2  = q.req_s1;
      d.req_p   = q.req_s2;
      d.ctl_s1  = {ACK_STROBE_N, WR_N, RD_N, CS_N};
      d.ctl_s2  = q.ctl_s1;
      d.ctl_p   = q.ctl_s2;
      d.addr_s1 = ADDR;
      d.addr_s2 = q.addr_s1;
      d.din_s1  = DIN;
      d.din_s2  = q.din_s1;

      // Acknowledge sequence
      case (q.st)
         icc_pkg::ST_IDLE: begin
            if (ack_fall) begin
               // Winner frozen here; no winner yields the spare vector
               d.svc_lvl = eligible ? pend_rq.level : icc_pkg::SPUR_LEVEL;
               d.svc_ok  = eligible;
               d.st      = icc_pkg::ST_ACK1;
            end
         end
         icc_pkg::ST_ACK1: begin
            if (ack_rise) begin
               if (q.svc_ok) begin
                  isr_set = isr_set | onehot(q.svc_lvl);
                  irr_clr = irr_clr | onehot(q.svc_lvl);
               end
               d.st = icc_pkg::ST_GAP;
            end
         end
         icc_pkg::ST_GAP: begin
            if (ack_fall) begin
               // One byte: base bits over the level number
               d.dout    = {q.iw2[7:icc_pkg::VEC_BASE_LSB], q.svc_lvl};
               d.dout_en = 1'b1;
               d.st      = icc_pkg::ST_ACK2;
            end
         end
         icc_pkg::ST_ACK2: begin
            if (ack_rise) begin
               d.dout_en = 1'b0;
               if (q.iw4[icc_pkg::IW4_AUTO_END_OF_SERVICE_BIT] && serv_rq.valid) begin
                  isr_clr = isr_clr | onehot(serv_rq.level);
                  if (q.rot_auto_end_of_service) begin
                     d.lowest = serv_rq.level;
                  end
               end
               d.st = icc_pkg::ST_IDLE;
            end
         end
         default: begin
            d.st = icc_pkg::ST_IDLE;
         end
      endcase

      // Register writes
      if (wr_take) begin
         case (q.addr_s2)
            icc_pkg::ADDR_OP: begin
               if (q.din_s2[icc_pkg::OW_SEL_BIT]) begin
                  if (q.din_s2[icc_pkg::OW3_ESMM_BIT]) begin
                     d.selective_mask_mode = q.din_s2[icc_pkg::OW3_SMM_BIT];
                  end
                  if (q.din_s2[icc_pkg::OW3_RR_BIT]) begin
                     d.read_isr = q.din_s2[icc_pkg::OW3_RIS_BIT];
                  end
                  d.poll_arm = q.din_s2[icc_pkg::OW3_POLL_BIT];
               end else begin
                  case (q.din_s2[7:icc_pkg::OW2_CMD_LSB])
                     icc_pkg::OW2_NS_EOI: begin
                        if (serv_rq.valid) begin
                           isr_clr = isr_clr | onehot(serv_rq.level);
                        end
                     end
                     icc_pkg::OW2_ROT_NS_EOI: begin
                        if (serv_rq.valid) begin
                           isr_clr  = isr_clr | onehot(serv_rq.level);
                           d.lowest = serv_rq.level;
                        end
                     end
                     icc_pkg::OW2_SP_EOI: begin
                        isr_clr = isr_clr | onehot(cmd_lvl);
                     end
                     icc_pkg::OW2_ROT_SP_EOI: begin
                        isr_clr  = isr_clr | onehot(cmd_lvl);
                        d.lowest = cmd_lvl;
                     end
                     icc_pkg::OW2_SET_PRIO: begin
                        d.lowest = cmd_lvl;
                     end
                     icc_pkg::OW2_ROT_AUTO_END_OF_SERVICE_SET: begin
                        d.rot_auto_end_of_service = 1'b1;
                     end
                     icc_pkg::OW2_ROT_AUTO_END_OF_SERVICE_CLR: begin
                        d.rot_auto_end_of_service = 1'b0;
                     end
                     default: begin
                     end
                  endcase
               end
            end
            icc_pkg::ADDR_MASK: d.imr = q.din_s2;
            icc_pkg::ADDR_IW1:  d.iw1 = q.din_s2;
            icc_pkg::ADDR_IW2:  d.iw2 = q.din_s2;
            icc_pkg::ADDR_IW4:  d.iw4 = q.din_s2;
            default: begin
            end
         endcase
      end

      // Register reads; a poll read claims the winner at the read's fall
      if (rd_take) begin
         d.dout_en = 1'b1;
         case (q.addr_s2)
            icc_pkg::ADDR_OP: begin
               if (q.poll_arm) begin
                  d.poll_arm = 1'b0;
                  d.dout     = {eligible, 4'h0, pend_rq.level};
                  if (eligible) begin
                     isr_set = isr_set | onehot(pend_rq.level);
                     irr_clr = irr_clr | onehot(pend_rq.level);
                  end
               end else begin
                  d.dout = q.read_isr ? q.in_service_bits : q.pending_request_bits;
               end
            end
            icc_pkg::ADDR_MASK: d.dout = q.imr;
            icc_pkg::ADDR_IW1:  d.dout = q.iw1;
            icc_pkg::ADDR_IW2:  d.dout = q.iw2;
            icc_pkg::ADDR_IW4:  d.dout = q.iw4;
            default:            d.dout = 8'h00;
         endcase
      end else if (q.ctl_s2[icc_pkg::CTL_RD] && d.st != icc_pkg::ST_ACK2) begin
         d.dout_en = 1'b0;
      end

      // Pending bits; a new edge beats a claim in the same cycle
      if (level_mode) begin
         if (q.st == icc_pkg::ST_IDLE) begin
            irr_set = q.req_s2;
            irr_clr = irr_clr | ~q.req_s2;
         end
      end else begin
         irr_set = q.req_s2 & ~q.req_p;
      end
      d.pending_request_bits = (q.pending_request_bits & ~irr_clr) | irr_set;
      d.in_service_bits = (q.in_service_bits & ~isr_clr) | isr_set;

      // Request held back while a sequence is running
      d.irq = eligible && (q.st == icc_pkg::ST_IDLE);
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         q          <= '0;
         q.ctl_s1   <= 4'hF;
         q.ctl_s2   <= 4'hF;
         q.ctl_p    <= 4'hF;
         q.imr      <= icc_pkg::MASK_RST;
         q.iw1      <= icc_pkg::IW_RST;
         q.iw2      <= icc_pkg::IW_RST;
         q.iw4      <= icc_pkg::IW_RST;
         q.lowest   <= icc_pkg::LOWEST_RST;
         q.st       <= icc_pkg::ST_IDLE;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from flops
   assign READ_BUS    = q.dout;
   assign READ_BUS_EN = q.dout_en;
   assign IRQ_OUT     = q.irq;

endmodule

//--- icc_interrupt_controller_tb.sv
// Purpose: Self-checking bench of the interrupt controller
// Assumes: Host model drives all bus and acknowledge pins
// Notes:   Scenarios run in order and share the state left behind

`timescale 1ns/10ps

`define CHK(got, exp, msg) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, exp); \
      end \
   end

module icc_interrupt_controller_tb;
   localparam logic [7:0] BASE  = 8'hA8;
   localparam int         LIMIT = 20000; // About thirty times the expected run
   logic       CORE_CLK, RSTN, CS_N, RD_N, WR_N, ACK_STROBE_N, READ_BUS_EN, IRQ_OUT;
   logic [2:0] ADDR;
   logic [7:0] DIN, REQUEST_LINE, READ_BUS;
   int         miscompares = 0;
   int         tests_run   = 0;
   int         cycles      = 0;

   // ****************************************
   // Design, host and helpers
   // ****************************************
   icc_interrupt_controller dut_u (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .CS_N(CS_N),
      .RD_N(RD_N), .WR_N(WR_N), .ADDR(ADDR), .DIN(DIN), .ACK_STROBE_N(ACK_STROBE_N),
      .REQUEST_LINE(REQUEST_LINE), .READ_BUS(READ_BUS), .READ_BUS_EN(READ_BUS_EN),
      .IRQ_OUT(IRQ_OUT));
   icc_host_model host_u (.clk(CORE_CLK), .read_bus(READ_BUS), .read_bus_en(READ_BUS_EN),
      .cs_n(CS_N), .rd_n(RD_N), .wr_n(WR_N), .addr(ADDR), .din(DIN), .ack_n(ACK_STROBE_N));

   function automatic logic [7:0] vec(input logic [2:0] l);
      return {BASE[7:3], l};
   endfunction
   task automatic opw(input logic [7:0] d);
      host_u.wr(icc_pkg::ADDR_OP, d);
   endtask
   task automatic status(input logic [7:0] sel, output logic [7:0] v);
      opw(sel);
      host_u.rd(icc_pkg::ADDR_OP, v);
   endtask
   // Long enough for the two-flop synchroniser and the irq register
   task automatic pulse(input logic [7:0] l);
      REQUEST_LINE = REQUEST_LINE | l;
      host_u.step(4);
      REQUEST_LINE = REQUEST_LINE & ~l;
      host_u.step(2);
   endtask

   task automatic s_reset();
      logic [7:0] v;
      host_u.rd(icc_pkg::ADDR_MASK, v);
      `CHK(v, icc_pkg::MASK_RST, "mask after reset")
      host_u.rd(3'h5, v);
      `CHK(v, 8'h00, "unmapped read")
      pulse(8'h01);
      `CHK(IRQ_OUT, 1'b0, "irq under full mask")
      status(8'h0A, v);
      `CHK(v, 8'h01, "pending bits")
   endtask

   task automatic s_nested();
      logic [7:0] v;
      host_u.wr(icc_pkg::ADDR_IW2, BASE);
      host_u.wr(icc_pkg::ADDR_MASK, 8'h00);
      `CHK(IRQ_OUT, 1'b1, "irq after unmask")
      REQUEST_LINE = 8'h08;
      host_u.ack(v);
      `CHK(v, vec(3'h0), "level 0 first")
      `CHK(IRQ_OUT, 1'b0, "lower level held off")
      opw(8'h20);
      host_u.ack(v);
      `CHK(v, vec(3'h3), "level 3 after end")
      opw(8'h63);
      status(8'h0B, v);
      `CHK(v, 8'h00, "specific end")
      status(8'h0A, v);
      `CHK(v, 8'h00, "held line not pending")
      REQUEST_LINE = 8'h00;
   endtask

   task automatic s_poll();
      logic [7:0] v;
      pulse(8'h02);
      opw(8'h0C);
      host_u.rd(icc_pkg::ADDR_OP, v);
      `CHK(v, 8'h81, "poll word")
      status(8'h0B, v);
      `CHK(v, 8'h02, "poll claims level")
      opw(8'h20);
      opw(8'h0C);
      host_u.rd(icc_pkg::ADDR_OP, v);
      `CHK(v[7], 1'b0, "no pending flag")
   endtask

   task automatic s_rotate();
      logic [7:0] v;
      host_u.wr(icc_pkg::ADDR_IW4, 8'h02);
      opw(8'h80);
      pulse(8'h20);
      host_u.ack(v);
      `CHK(v, vec(3'h5), "level 5")
      status(8'h0B, v);
      `CHK(v, 8'h00, "auto end")
      pulse(8'h50);
      host_u.ack(v);
      `CHK(v, vec(3'h6), "6 above 4")
      opw(8'hC3);
      pulse(8'h04);
      host_u.ack(v);
      `CHK(v, vec(3'h4), "4 above 2")
      host_u.ack(v);
      `CHK(v, vec(3'h2), "2 last")
   endtask

   // Selective mask lets a lower level through past a served one
   task automatic s_smm();
      logic [7:0] v;
      opw(8'h68);
      opw(8'hC7);
      pulse(8'h01);
      opw(8'h0C);
      host_u.rd(icc_pkg::ADDR_OP, v);
      `CHK(v, 8'h80, "poll claims level 0")
      pulse(8'h04);
      `CHK(IRQ_OUT, 1'b1, "lower level under selective mask")
      host_u.wr(icc_pkg::ADDR_MASK, 8'h04);
      `CHK(IRQ_OUT, 1'b0, "masked level under selective mask")
      host_u.wr(icc_pkg::ADDR_MASK, 8'h00);
      opw(8'h48);
      `CHK(IRQ_OUT, 1'b0, "nested order back")
      opw(8'h20);
      `CHK(IRQ_OUT, 1'b1, "served level ended")
      host_u.ack(v);
      `CHK(v, vec(3'h2), "level 2 vector")
   endtask

   task automatic s_level();
      logic [7:0] v;
      host_u.wr(icc_pkg::ADDR_IW1, 8'h08);
      REQUEST_LINE = 8'h80; // Held past the first ack fall
      host_u.step(6);
      host_u.ack(v);
      `CHK(v, vec(3'h7), "level request")
      host_u.step(4);
      `CHK(IRQ_OUT, 1'b1, "held level asks again")
      REQUEST_LINE = 8'h00;
      host_u.step(6);
      `CHK(IRQ_OUT, 1'b0, "level withdrawn")
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ****************************************
   // Clock, watchdog and main sequence
   // ****************************************
   always #25 CORE_CLK = ~CORE_CLK;

   // A hang counts as a mismatch
   always @(posedge CORE_CLK) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         give_verdict();
      end
   end

   initial begin
      CORE_CLK     = 1'b0;
      RSTN         = 1'b0;
      REQUEST_LINE = 8'h00;
      repeat (8) @(posedge CORE_CLK);
      #1;
      RSTN = 1'b1;
      host_u.step(1);
      s_reset();
      s_nested();
      s_poll();
      s_rotate();
      s_smm();
      s_level();
      give_verdict();
   end
endmodule

//--- icc_pkg.sv
// Purpose: Shared constants and types of the interrupt controller
// Assumes: Eight request levels, byte-wide host data bus
// Notes:   Offsets are values of the ADDR pins of the top module

package icc_pkg;

   // ****************************************
   // Register offsets on ADDR
   // ****************************************
   localparam logic [2:0] ADDR_OP   = 3'h0; // Op words, poll word
   localparam logic [2:0] ADDR_MASK = 3'h1;
   localparam logic [2:0] ADDR_IW1  = 3'h2;
   localparam logic [2:0] ADDR_IW2  = 3'h3;
   localparam logic [2:0] ADDR_IW4  = 3'h4;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int IW1_LEVEL_BIT = 3;   // High selects level trigger
   localparam int IW4_AUTO_END_OF_SERVICE_BIT  = 1;
   localparam int VEC_BASE_LSB  = 3;   // Base bits 7..3 of init word two
   localparam int OW_SEL_BIT    = 3;   // High selects op word three
   localparam int OW2_CMD_LSB   = 5;
   localparam int OW3_RIS_BIT   = 0;
   localparam int OW3_RR_BIT    = 1;
   localparam int OW3_POLL_BIT  = 2;
   localparam int OW3_SMM_BIT   = 5;
   localparam int OW3_ESMM_BIT  = 6;
   localparam int POLL_FLAG_BIT = 7;
   localparam int CTL_CS        = 0;   // Index in synchronised strobes
   localparam int CTL_RD        = 1;
   localparam int CTL_WR        = 2;
   localparam int CTL_ACK       = 3;

   // ****************************************
   // Reset values and spare level
   // ****************************************
   localparam logic [7:0] MASK_RST   = 8'hFF; // Idle until set up
   localparam logic [7:0] IW_RST     = 8'h00;
   localparam logic [2:0] LOWEST_RST = 3'h7;  // Level 0 on top
   localparam logic [2:0] SPUR_LEVEL = 3'h7;  // Vector with no winner

   // ****************************************
   // Op word two commands, bits 7..5
   // ****************************************
   typedef enum logic [2:0] {
      OW2_ROT_AUTO_END_OF_SERVICE_CLR = 3'b000,
      OW2_NS_EOI       = 3'b001,
      OW2_NOP          = 3'b010,
      OW2_SP_EOI       = 3'b011,
      OW2_ROT_AUTO_END_OF_SERVICE_SET = 3'b100,
      OW2_ROT_NS_EOI   = 3'b101,
      OW2_SET_PRIO     = 3'b110,
      OW2_ROT_SP_EOI   = 3'b111
   } icc_cmd_type;

   // ****************************************
   // Acknowledge sequence states
   // ****************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACK1 = 2'b01,
      ST_GAP  = 2'b10,
      ST_ACK2 = 2'b11
   } icc_state_type;

endpackage

//--- icc_res_if.sv
// Purpose: Carries one priority question and its answer
// Assumes: Bit n of req stands for level n
// Notes:   Answer is purely combinational

`timescale 1ns/10ps

interface icc_res_if;
   logic [7:0] req;    // Candidate levels
   logic [2:0] lowest; // Level of lowest priority
   logic       valid;  // Any candidate
   logic [2:0] level;  // Candidate of highest priority

   modport ctl (output req, output lowest, input valid, input level);
   modport res (input req, input lowest, output valid, output level);
endinterface

//--- icc_resolver.sv
// Purpose: Finds the highest-priority set bit under a rotating order
// Assumes: Priority runs from lowest+1 (top) round to lowest (bottom)
// Notes:   Pure logic, no state

`timescale 1ns/10ps

module icc_resolver (
   icc_res_if.res p
);

   // ****************************************
   // Scan from bottom to top, last hit wins
   // ****************************************
   always_comb begin
      logic [2:0] lvl;
      lvl     = 3'h0;
      p.valid = 1'b0;
      p.level = 3'h0;
      for (int r = 7; r >= 0; r--) begin
         lvl = p.lowest + 3'(r) + 3'h1; // Wraps after level 7
         if (p.req[lvl]) begin
            p.valid = 1'b1;
            p.level = lvl;
         end
      end
   end

endmodule
